// ===== rtl/mmir_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01 - The slave address is 0101 in the top nibble, three strap bits below, and the direction bit last.
// R02 - Address bits 3, 2 and 1 come from strap pins 2, 1 and 0 as sampled from the board.
// R03 - Any transmit fault, loss of input signal or monitor flag raises the host interrupt; here only when all sources were clear the cycle before.
// R04 - The interrupt signals as a pulse or a static level, chosen by command, pulse after reset.
// R05 - The interrupt pin is only ever driven low, and released otherwise for the external pull-up.
// R06 - While module reset is low all optical transmit outputs stay disabled.
// R07 - While module reset is low all serial management commands are ignored.
// R08 - Module reset returns every setting to its default or stored value.
// R09 - An open module reset pin reads high, so the module is not held in reset.
// R10 - Static mode holds the interrupt until flags are read or cleared; pulse mode gives one bounded pulse per event; here events in a pulse merge into it.
module mmir_top
#(
	parameter int LANES = mmir_pkg::LANES,
	parameter int MON_FLAGS = mmir_pkg::MON_FLAGS
)
(
	// system clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// link side: decoded serial command words
	input wire logic clk_link_i,
	input wire logic link_cmd_valid_i,
	input wire logic [mmir_pkg::ADDR_W-1:0] link_cmd_addr_i,
	input wire logic [mmir_pkg::DATA_W-1:0] link_cmd_data_i,
	output logic link_cmd_ready_o,
	// module pins
	input wire logic [mmir_pkg::STRAP_W-1:0] adr_i,
	input wire logic module_reset_n_i,
	input wire logic host_irq_n_i,
	output logic host_irq_n_o,
	output logic host_irq_n_oe_o,
	output logic tx_disable_o,
	// event sources and stored setting
	input wire logic [LANES-1:0] tx_fault_i,
	input wire logic [LANES-1:0] los_i,
	input wire logic [MON_FLAGS-1:0] mon_flag_i,
	input wire logic nv_static_mode_i,
	// status
	output logic [mmir_pkg::ADDR_W-2:0] slave_addr_o,
	output logic irq_static_mode_o,
	output logic irq_pending_o,
	output logic irq_line_low_o,
	output logic cmd_taken_o
);

	function automatic logic addr_hit(input logic [mmir_pkg::ADDR_W-1:0] a,
		input logic [mmir_pkg::STRAP_W-1:0] strap);
		addr_hit = (a[mmir_pkg::ADDR_W-1:mmir_pkg::PREFIX_LSB] == mmir_pkg::ADDR_PREFIX)
			&& (a[mmir_pkg::PREFIX_LSB-1:mmir_pkg::STRAP_LSB] == strap);
	endfunction : addr_hit

	// ==========================================
	// link domain: hold one command word, toggle request
	logic [mmir_pkg::ADDR_W-1:0] lk_addr_reg;
	logic [mmir_pkg::DATA_W-1:0] lk_data_reg;
	logic lk_req_reg;
	logic lk_ack_s1_reg;
	logic lk_ack_s2_reg;
	logic lk_ack_s3_reg;
	logic lk_ack_seen_reg;
	logic lk_busy;
	// sys side acknowledge toggle, read here only through the three stages
	logic sy_ack_reg;

	// the word stays stable until the sys side answers; the link clock may
	// stop between frames, so ready returns on the next frame's edges
	assign lk_busy = (lk_req_reg != lk_ack_seen_reg);
	assign link_cmd_ready_o = !lk_busy;

	always_ff @(posedge clk_link_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lk_addr_reg <= '0;
			lk_data_reg <= '0;
			lk_req_reg <= 1'b0;
		end
		else if (link_cmd_valid_i && !lk_busy)
		begin
			lk_addr_reg <= link_cmd_addr_i;
			lk_data_reg <= link_cmd_data_i;
			lk_req_reg <= !lk_req_reg;
		end
	end

	always_ff @(posedge clk_link_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lk_ack_s1_reg <= 1'b0;
			lk_ack_s2_reg <= 1'b0;
			lk_ack_s3_reg <= 1'b0;
			lk_ack_seen_reg <= 1'b0;
		end
		else
		begin
			lk_ack_s1_reg <= sy_ack_reg;
			lk_ack_s2_reg <= lk_ack_s1_reg;
			lk_ack_s3_reg <= lk_ack_s2_reg;
			if (lk_ack_s2_reg == lk_ack_s3_reg)
				lk_ack_seen_reg <= lk_ack_s3_reg;
		end
	end

	// ==========================================
	// sys domain: request crossing
	logic sy_req_s1_reg;
	logic sy_req_s2_reg;
	logic sy_req_s3_reg;
	logic new_cmd;

	assign new_cmd = (sy_req_s2_reg == sy_req_s3_reg) && (sy_req_s3_reg != sy_ack_reg);

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sy_req_s1_reg <= 1'b0;
			sy_req_s2_reg <= 1'b0;
			sy_req_s3_reg <= 1'b0;
			sy_ack_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			sy_req_s1_reg <= lk_req_reg;
			sy_req_s2_reg <= sy_req_s1_reg;
			sy_req_s3_reg <= sy_req_s2_reg;
			if (new_cmd)
				sy_ack_reg <= sy_req_s3_reg;
		end
	end

	// ==========================================
	// pin synchroniser with agreement filter
	logic [mmir_pkg::PIN_W-1:0] pin_s1_reg;
	logic [mmir_pkg::PIN_W-1:0] pin_s2_reg;
	logic [mmir_pkg::PIN_W-1:0] pin_s3_reg;
	logic [mmir_pkg::PIN_W-1:0] pin_reg;
	logic mreset_active;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			// module reset filter starts high, as the pad pull-up would hold it
			pin_s1_reg <= mmir_pkg::PIN_RESET; // [R09]
			pin_s2_reg <= mmir_pkg::PIN_RESET;
			pin_s3_reg <= mmir_pkg::PIN_RESET;
			pin_reg <= mmir_pkg::PIN_RESET;
		end
		else if (ce_i)
		begin
			pin_s1_reg <= {host_irq_n_i, module_reset_n_i, adr_i};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			for (int i = 0; i < mmir_pkg::PIN_W; i++)
				if (pin_s2_reg[i] == pin_s3_reg[i])
					pin_reg[i] <= pin_s3_reg[i];
		end
	end

	assign mreset_active = !pin_reg[mmir_pkg::PIN_MRST];

	// ==========================================
	// strap capture, redone while the module is held in reset
	logic [mmir_pkg::STRAP_W-1:0] strap_reg;
	logic strap_vld_reg;
	logic strap_stable;
	logic strap_go;
	localparam int SYNC_DEPTH = 3;
	logic [SYNC_DEPTH-1:0] fill_reg;

	// the stages hold reset values until real pin samples reach the end
	assign strap_stable = (pin_s2_reg[mmir_pkg::STRAP_W-1:0] == pin_s3_reg[mmir_pkg::STRAP_W-1:0]);
	assign strap_go = strap_stable && fill_reg[SYNC_DEPTH-1];

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			fill_reg <= '0;
		else if (ce_i)
			fill_reg <= {fill_reg[SYNC_DEPTH-2:0], 1'b1};
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strap_reg <= '0;
			strap_vld_reg <= 1'b0;
		end
		else if (ce_i && strap_go && (!strap_vld_reg || mreset_active))
		begin
			strap_reg <= pin_s3_reg[mmir_pkg::STRAP_W-1:0]; // [R02]
			strap_vld_reg <= 1'b1;
		end
	end

	assign slave_addr_o = {mmir_pkg::ADDR_PREFIX, strap_reg}; // [R01]

	// ==========================================
	// command execution
	logic cmd_ok;
	logic cmd_read;
	logic clr_p;
	logic static_mode_reg;

	// a read of the address counts as reading the flags
	assign cmd_ok = new_cmd && !mreset_active && strap_vld_reg
		&& addr_hit(lk_addr_reg, strap_reg); // [R01] [R07]
	assign cmd_read = (lk_addr_reg[mmir_pkg::RW_BIT] == mmir_pkg::DIR_READ);
	assign clr_p = cmd_ok && (cmd_read || lk_data_reg[mmir_pkg::CMD_CLEAR_BIT]); // [R10]

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			static_mode_reg <= mmir_pkg::MODE_RESET; // [R04]
		else if (ce_i)
		begin
			if (mreset_active)
				static_mode_reg <= nv_static_mode_i; // [R08]
			else if (cmd_ok && !cmd_read)
				static_mode_reg <= lk_data_reg[mmir_pkg::CMD_MODE_BIT]; // [R04]
		end
	end

	// ==========================================
	// events and pending flag
	logic evt_any;
	logic evt_prev_reg;
	logic evt_rise;
	logic pend_reg;

	assign evt_any = (|tx_fault_i) || (|los_i) || (|mon_flag_i); // [R03]
	assign evt_rise = evt_any && !evt_prev_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			evt_prev_reg <= 1'b0;
			pend_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			evt_prev_reg <= evt_any;
			// set wins over a clear in the same cycle
			if (evt_rise)
				pend_reg <= 1'b1; // [R03]
			else if (clr_p || mreset_active)
				pend_reg <= 1'b0; // [R08]
		end
	end

	// ==========================================
	// interrupt generator and pin
	mmir_irq_if irq_bus ();

	assign irq_bus.event_p = evt_rise; // [R03]
	assign irq_bus.static_mode = static_mode_reg;
	assign irq_bus.clear_p = clr_p || mreset_active;

	mmir_irq_gen u_irq_gen (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.irq(irq_bus.gen)
	);

	// open drain: data held low, only the enable moves
	assign host_irq_n_o = 1'b0; // [R05]
	assign host_irq_n_oe_o = irq_bus.active; // [R05]

	// ==========================================
	// registered status outputs
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_disable_o <= 1'b1;
			cmd_taken_o <= 1'b0;
			irq_line_low_o <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_disable_o <= mreset_active; // [R06]
			cmd_taken_o <= cmd_ok;
			irq_line_low_o <= !pin_reg[mmir_pkg::PIN_IRQ];
		end
	end

	assign irq_static_mode_o = static_mode_reg;
	assign irq_pending_o = pend_reg;

	// ==========================================
	// checks
	addr_prefix_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R01]
		slave_addr_o[mmir_pkg::ADDR_W-2:mmir_pkg::STRAP_W] == mmir_pkg::ADDR_PREFIX)
		else $error("address prefix wrong");

	strap_take_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R02]
		(!strap_vld_reg && strap_go)
		|=> strap_vld_reg && strap_reg == $past(pin_s3_reg[mmir_pkg::STRAP_W-1:0]))
		else $error("strap not captured");

	irq_raise_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R03]
		evt_rise |=> host_irq_n_oe_o)
		else $error("event did not raise interrupt");

	od_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R05]
		!host_irq_n_o && (host_irq_n_oe_o == irq_bus.active))
		else $error("interrupt pin driven high");

	tx_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R06]
		mreset_active |=> tx_disable_o)
		else $error("transmit not disabled in module reset");

	cmd_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R07]
		(mreset_active && new_cmd) |=> !cmd_taken_o)
		else $error("command taken during module reset");

	sequence mrst_held_s;
		mreset_active [*2];
	endsequence

	defaults_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R08]
		mrst_held_s |-> static_mode_reg == $past(nv_static_mode_i) && !pend_reg)
		else $error("settings not restored in module reset");

	mode_after_rst_a: assert property (@(posedge clk_sys_i) // [R04]
		$fell(rst_i) |-> static_mode_reg == mmir_pkg::MODE_PULSE)
		else $error("mode not pulse after reset");

	link_hold_a: assert property (@(posedge clk_link_i) disable iff (rst_i)
		lk_busy |=> $stable(lk_addr_reg) && $stable(lk_data_reg))
		else $error("command word changed while busy");

endmodule : mmir_top

`default_nettype wire

// ===== common/mmir_pkg.sv
package mmir_pkg;

	// ==========================================
	// serial address layout
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int STRAP_W = 3;
	localparam int RW_BIT = 0;
	localparam int STRAP_LSB = 1;
	localparam int PREFIX_LSB = 4;
	localparam logic [3:0] ADDR_PREFIX = 4'h5;
	localparam logic DIR_READ = 1'b1;

	// ==========================================
	// command data byte fields
	localparam int CMD_MODE_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;

	// ==========================================
	// interrupt signalling modes
	localparam logic MODE_PULSE = 1'b0;
	localparam logic MODE_STATIC = 1'b1;
	localparam logic MODE_RESET = MODE_PULSE;

	// ==========================================
	// widths and timing
	localparam int LANES = 12;
	localparam int MON_FLAGS = 8;
	localparam int CLK_PERIOD_NS = 50;
	localparam int IRQ_PULSE_NS = 1000;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS / CLK_PERIOD_NS < 1) ? 1
		: IRQ_PULSE_NS / CLK_PERIOD_NS;
	localparam int PULSE_CNT_W = 8;

	// ==========================================
	// pin synchroniser: straps, module reset, irq line readback
	localparam int PIN_W = STRAP_W + 2;
	localparam int PIN_MRST = STRAP_W;
	localparam int PIN_IRQ = STRAP_W + 1;
	localparam logic [PIN_W-1:0] PIN_RESET = 5'h18;

	typedef enum {IRQ_IDLE, IRQ_PULSE, IRQ_HOLD} mmir_irq_state_t;

endpackage : mmir_pkg

// ===== common/mmir_irq_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mmir_irq_if;
	logic event_p;
	logic static_mode;
	logic clear_p;
	logic active;

	modport gen (input event_p, input static_mode, input clear_p, output active);
	modport ctl (output event_p, output static_mode, output clear_p, input active);
endinterface : mmir_irq_if

`default_nettype wire

// ===== rtl/mmir_irq_gen.sv
`timescale 1ns/1ps
`default_nettype none

module mmir_irq_gen
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control side
	mmir_irq_if.gen irq
);

	localparam logic [mmir_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
		mmir_pkg::PULSE_CNT_W'(mmir_pkg::IRQ_PULSE_CYC - 1);

	mmir_pkg::mmir_irq_state_t state_reg;
	logic [mmir_pkg::PULSE_CNT_W-1:0] cnt_reg;

	// ==========================================
	// state machine
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= mmir_pkg::IRQ_IDLE;
			cnt_reg <= '0;
		end
		else if (ce_i)
		begin
			unique case (state_reg)
				mmir_pkg::IRQ_IDLE:
				begin
					if (irq.event_p && irq.static_mode == mmir_pkg::MODE_STATIC)
						state_reg <= mmir_pkg::IRQ_HOLD; // [R10]
					else if (irq.event_p)
					begin
						state_reg <= mmir_pkg::IRQ_PULSE; // [R10]
						cnt_reg <= PULSE_LOAD;
					end
				end
				mmir_pkg::IRQ_PULSE:
				begin
					// events during the pulse merge into it
					if (cnt_reg == '0)
						state_reg <= mmir_pkg::IRQ_IDLE; // [R10]
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
				mmir_pkg::IRQ_HOLD:
				begin
					// a new event in the clear cycle keeps the line held
					if (irq.clear_p && !irq.event_p)
						state_reg <= mmir_pkg::IRQ_IDLE; // [R10]
				end
			endcase
		end
	end

	assign irq.active = (state_reg != mmir_pkg::IRQ_IDLE);

	// ==========================================
	// checks
	// pulse length counted apart from the down-counter, so a bad load shows up
	logic [mmir_pkg::PULSE_CNT_W-1:0] pw_len_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			pw_len_reg <= '0;
		else if (ce_i)
		begin
			if (state_reg == mmir_pkg::IRQ_PULSE)
				pw_len_reg <= pw_len_reg + 1'b1;
			else
				pw_len_reg <= '0;
		end
	end

	sequence pulse_start_s;
		state_reg == mmir_pkg::IRQ_IDLE && irq.event_p && !irq.static_mode;
	endsequence

	sequence pulse_end_s;
		state_reg == mmir_pkg::IRQ_PULSE ##1 state_reg == mmir_pkg::IRQ_IDLE;
	endsequence

	pulse_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R10]
		pulse_start_s |=> irq.active)
		else $error("interrupt pulse not started");

	pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R10]
		pulse_end_s |-> $past(pw_len_reg) == PULSE_LOAD)
		else $error("interrupt pulse width wrong");

	static_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i) // [R10]
		(state_reg == mmir_pkg::IRQ_HOLD && !irq.clear_p) |=> irq.active)
		else $error("static interrupt dropped without clear");

endmodule : mmir_irq_gen

`default_nettype wire

// ===== verification/mmir_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mmir_host_model
(
	// link side
	output logic clk_link_o,
	output logic cmd_valid_o,
	output logic [mmir_pkg::ADDR_W-1:0] cmd_addr_o,
	output logic [mmir_pkg::DATA_W-1:0] cmd_data_o,
	input wire logic cmd_ready_i,
	// interrupt line
	input wire logic irq_drv_i,
	input wire logic irq_oe_i,
	output logic irq_line_o
);
	// ==========================================
	// wired line: board pull-up unless the module pulls low
	assign irq_line_o = (irq_oe_i && !irq_drv_i) ? 1'b0 : 1'b1;

	initial
	begin
		clk_link_o = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_addr_o = 8'h00;
		cmd_data_o = 8'h00;
	end

	// ==========================================
	// link clock runs only inside a frame, 80 ns period
	task automatic rise();
		#39 clk_link_o = 1'b0;
		#40 clk_link_o = 1'b1;
		#1;
	endtask : rise

	task automatic park();
		#39 clk_link_o = 1'b0;
	endtask : park

	task automatic send(input logic [7:0] addr, input logic [7:0] data, input int gap);
		int n;
		repeat (gap) rise();
		cmd_addr_o = addr;
		cmd_data_o = data;
		cmd_valid_o = 1'b1;
		n = 0;
		while (cmd_ready_i !== 1'b1 && n < 40)
		begin
			rise();
			n++;
		end
		rise();
		cmd_valid_o = 1'b0;
		// released lines must not keep showing the old word
		cmd_addr_o = ~addr;
		cmd_data_o = ~data;
		rise();
		rise();
		n = 0;
		while (cmd_ready_i !== 1'b1 && n < 40)
		begin
			rise();
			n++;
		end
		park();
	endtask : send
endmodule : mmir_host_model

`default_nettype wire

// ===== verification/mmir_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mmir_top_tb;
	// ==========================================
	// signals
	logic clk_sys_i, rst_i, ce, clk_link, l_valid, l_ready, mrst_n, nv_mode;
	logic irq_line, irq_drv, irq_oe, tx_dis, mode, pending, line_low, taken;
	logic [7:0] l_addr, l_data, mon;
	logic [11:0] tx_fault, los;
	logic [2:0] adr;
	logic [6:0] slave_addr;
	logic [31:0] rnd;
	int failures, total_checks, taken_cnt, w, k;

	mmir_top mmir_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.clk_link_i(clk_link), .link_cmd_valid_i(l_valid), .link_cmd_addr_i(l_addr),
		.link_cmd_data_i(l_data), .link_cmd_ready_o(l_ready), .adr_i(adr),
		.module_reset_n_i(mrst_n), .host_irq_n_i(irq_line), .host_irq_n_o(irq_drv),
		.host_irq_n_oe_o(irq_oe), .tx_disable_o(tx_dis), .tx_fault_i(tx_fault),
		.los_i(los), .mon_flag_i(mon), .nv_static_mode_i(nv_mode),
		.slave_addr_o(slave_addr), .irq_static_mode_o(mode), .irq_pending_o(pending),
		.irq_line_low_o(line_low), .cmd_taken_o(taken));

	mmir_host_model mmir_host_model_inst (.clk_link_o(clk_link), .cmd_valid_o(l_valid),
		.cmd_addr_o(l_addr), .cmd_data_o(l_data), .cmd_ready_i(l_ready),
		.irq_drv_i(irq_drv), .irq_oe_i(irq_oe), .irq_line_o(irq_line));

	// ==========================================
	// clock, command counter, watchdog
	initial
	begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
		if (taken === 1'b1)
			taken_cnt++;

	initial
	begin
		#1_000_000;
		failures++;
		finish_test();
	end

	// ==========================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] dev_addr(input logic [2:0] strap);
		return {mmir_pkg::ADDR_PREFIX, strap, 1'b0};
	endfunction : dev_addr

	task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_vec

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc

	task automatic cmd(input logic [7:0] addr, input logic [7:0] data);
		rnd = lfsr(rnd);
		mmir_host_model_inst.send(addr, data, int'(rnd[1:0]));
		cyc(2);
	endtask : cmd

	// raise one source bit, measure how long the line is held low
	task automatic fire(input int lim, output int width);
		int n;
		rnd = lfsr(rnd);
		@(negedge clk_sys_i);
		case (rnd[1:0])
			2'h0: tx_fault[rnd[7:4] % 12] = 1'b1;
			2'h1: los[rnd[7:4] % 12] = 1'b1;
			default: mon[rnd[6:4]] = 1'b1;
		endcase
		n = 0;
		while (irq_oe !== 1'b1 && n < 4)
		begin
			cyc(1);
			n++;
		end
		check_vec({7'h0, irq_line}, 8'h00);
		check_vec({7'h0, pending}, 8'h01);
		width = 0;
		while (irq_oe === 1'b1 && width < lim)
		begin
			cyc(1);
			width++;
		end
	endtask : fire

	task automatic drop();
		tx_fault = '0;
		los = '0;
		mon = '0;
	endtask : drop

	task automatic finish_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// ==========================================
	// main sequence
	initial
	begin
		rnd = 32'h2627ff4b;
		rst_i = 1'b1;
		ce = 1'b1;
		mrst_n = 1'b1;
		nv_mode = 1'b0;
		adr = rnd[2:0];
		drop();
		failures = 0;
		total_checks = 0;
		taken_cnt = 0;
		repeat (16) @(negedge clk_sys_i);
		mmir_host_model_inst.rise();
		mmir_host_model_inst.rise();
		mmir_host_model_inst.park();
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		cyc(8);
		check_vec({1'b0, slave_addr}, {1'b0, mmir_pkg::ADDR_PREFIX, adr});
		check_vec({7'h0, tx_dis}, 8'h00);
		check_vec({7'h0, mode}, {7'h0, mmir_pkg::MODE_PULSE});
		check_vec({6'h0, irq_line, irq_drv}, 8'h02);
		// pulse mode: one bounded pulse per new event, none while held
		for (k = 0; k < 6; k++)
		begin
			fire(100, w);
			check_vec(8'(w), 8'(mmir_pkg::IRQ_PULSE_CYC));
			cyc(5);
			check_vec({6'h0, irq_line, irq_oe}, 8'h02);
			drop();
			cyc(2);
		end
		// clock enable low freezes the edge detector and the generator
		ce = 1'b0;
		mon[0] = 1'b1;
		cyc(4);
		check_vec({7'h0, irq_oe}, 8'h00);
		ce = 1'b1;
		cyc(1);
		check_vec({7'h0, irq_oe}, 8'h01);
		cyc(24);
		drop();
		cyc(2);
		// static mode: held until cleared by command
		k = taken_cnt;
		cmd(dev_addr(adr), 8'h01);
		check_vec({7'h0, mode}, {7'h0, mmir_pkg::MODE_STATIC});
		check_vec(8'(taken_cnt - k), 8'h01);
		fire(60, w);
		check_vec(8'(w), 8'd60);
		check_vec({7'h0, line_low}, 8'h01);
		drop();
		cmd(dev_addr(adr), 8'h03);
		check_vec({6'h0, irq_line, irq_oe}, 8'h02);
		cyc(6);
		check_vec({7'h0, line_low}, 8'h00);
		// words for other addresses are ignored
		k = taken_cnt;
		cmd({4'h6, adr, 1'b0}, 8'h00);
		cmd({mmir_pkg::ADDR_PREFIX, adr ^ 3'h4, 1'b0}, 8'h00);
		check_vec(8'(taken_cnt - k), 8'h00);
		check_vec({7'h0, mode}, {7'h0, mmir_pkg::MODE_STATIC});
		// a read of the flags also releases a static interrupt
		fire(10, w);
		k = taken_cnt;
		cmd({mmir_pkg::ADDR_PREFIX, adr, mmir_pkg::DIR_READ}, 8'h00);
		check_vec(8'(taken_cnt - k), 8'h01);
		check_vec({7'h0, mode}, {7'h0, mmir_pkg::MODE_STATIC});
		check_vec({6'h0, irq_oe, pending}, 8'h00);
		drop();
		cyc(2);
		// module reset over a held interrupt, new straps, stored mode
		fire(10, w);
		rnd = lfsr(rnd);
		nv_mode = rnd[0];
		adr = rnd[3:1];
		mrst_n = 1'b0;
		cyc(6);
		check_vec({7'h0, tx_dis}, 8'h01);
		check_vec({7'h0, mode}, {7'h0, nv_mode});
		check_vec({6'h0, irq_oe, pending}, 8'h00);
		k = taken_cnt;
		cmd(dev_addr(adr), {7'h0, ~nv_mode});
		check_vec(8'(taken_cnt - k), 8'h00);
		check_vec({7'h0, mode}, {7'h0, nv_mode});
		drop();
		mrst_n = 1'b1;
		cyc(8);
		check_vec({7'h0, tx_dis}, 8'h00);
		check_vec({1'b0, slave_addr}, {1'b0, mmir_pkg::ADDR_PREFIX, adr});
		finish_test();
	end
endmodule : mmir_top_tb

`default_nettype wire
